/* test_async_serial_uart_ctrl_status.sv */
// Bench for the serial control block: bus tasks and scripted checks.
// Assumes the peripheral model on the serial side.
module test_async_serial_uart_ctrl_status;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'h0, rst_n = 1'h0, tck = 1'h0, rs = 1'h0, rw = 1'h1, stb = 1'h0;
    logic ext_n = 1'h1, psi_n = 1'h1;
    logic [7:0] tdat = 8'h00, rx_bus;
    logic [10:0] f;
    logic int_n, rdy_n, fe_o, er_o, he_n, rts_n, sout, sin, cts_n;
    int err_total = 0, num_checks = 0, cyc = 0;
    always #20 sys_clk = ~sys_clk;
    always #160 tck = ~tck;
    ucs_uart u_ucs_uart (.sys_clk(sys_clk), .rst_n(rst_n), .cs1(1'h1), .cs2_n(1'h0),
        .cs3(1'h1), .reg_select(rs), .rd_wr(rw), .bus_timing_strobe(stb), .tx_bus(tdat),
        .rx_bus(rx_bus), .int_n(int_n), .rx_char_ready_n(rdy_n), .frame_err_out(fe_o),
        .error_out(er_o), .tx_hold_empty_n(he_n), .rts_n(rts_n), .serial_out(sout),
        .serial_in(sin), .rx_clk(tck), .tx_clk(tck), .cts_n(cts_n), .ext_level_n(ext_n),
        .periph_edge_n(psi_n));
    ucs_periph u_ucs_periph (.sys_clk(sys_clk), .serial_in(sin), .cts_n(cts_n));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(input logic s, input logic w, input logic [7:0] d);
        @(posedge sys_clk);
        #1 rs = s;
        rw = w;
        tdat = d;
        stb = 1'h1;
        @(posedge sys_clk);
        #1 stb = 1'h0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input logic s, input logic [7:0] e);
        acc(s, 1'h1, 8'h00);
        chk(s ? "status" : "data", 11'(rx_bus), 11'(e));
    endtask
    task automatic pause;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1'h1;
        chk("sout", 11'(sout), 11'h1);
        rd(1'h1, 8'hC0);
        acc(1'h1, 1'h0, 8'h3A);
        u_ucs_periph.send(9'h0A5, 9, 1'h1);
        chk("int_n", 11'(int_n), 11'h0);
        chk("ready_n", 11'(rdy_n), 11'h0);
        rd(1'h1, 8'hC1);
        rd(1'h0, 8'hA5);
        chk("int_n", 11'(int_n), 11'h1);
        u_ucs_periph.send(9'h1A5, 9, 1'h0);
        rd(1'h1, 8'hCD);
        chk("err_pins", 11'({er_o, fe_o}), 11'h3);
        u_ucs_periph.send(9'h0A5, 9, 1'h1);
        rd(1'h1, 8'hC3);
        acc(1'h1, 1'h0, 8'h21);
        rd(1'h0, 8'hA5);
        u_ucs_periph.send(9'h015, 5, 1'h1);
        rd(1'h0, 8'h15);
        rd(1'h1, 8'hC0);
        ext_n = 1'h0;
        psi_n = 1'h0;
        pause();
        chk("int_n", 11'(int_n), 11'h0);
        rd(1'h1, 8'hF0);
        ext_n = 1'h1;
        psi_n = 1'h1;
        pause();
        chk("int_n", 11'(int_n), 11'h1);
        acc(1'h1, 1'h0, 8'h01);
        psi_n = 1'h0;
        pause();
        chk("int_n", 11'(int_n), 11'h1);
        rd(1'h1, 8'hE0);
        acc(1'h1, 1'h0, 8'h40);
        chk("sout", 11'(sout), 11'h0);
        acc(1'h1, 1'h0, 8'h00);
        chk("sout", 11'(sout), 11'h1);
        acc(1'h1, 1'h0, 8'h3A);
        acc(1'h1, 1'h0, 8'hC0);
        chk("rts_n", 11'(rts_n), 11'h0);
        chk("sout", 11'(sout), 11'h1);
        acc(1'h0, 1'h0, 8'h55);
        for (int i = 0; i < 3000 && sout; i++) begin
            @(posedge sys_clk);
            #1;
        end
        repeat (64) @(posedge sys_clk);
        for (int i = 0; i < 11; i++) begin
            f[i] = sout;
            repeat (128) @(posedge sys_clk);
        end
        #1 chk("frame", f, 11'h4AA);
        chk("he_int", 11'({he_n, int_n}), 11'h0);
        rd(1'h1, 8'hC0);
        chk("int_n", 11'(int_n), 11'h1);
        u_ucs_periph.set_cts(1'h1);
        pause();
        chk("int_n", 11'(int_n), 11'h0);
        rd(1'h1, 8'hC0);
        chk("int_n", 11'(int_n), 11'h1);
        acc(1'h0, 1'h0, 8'h0F);
        pause();
        chk("he_n", 11'(he_n), 11'h1);
        u_ucs_periph.set_cts(1'h0);
        pause();
        chk("he_n", 11'(he_n), 11'h0);
        test_done();
    end
endmodule

/* ucs_periph.sv */
// Serial peripheral model: drives the receive line and clear-to-send.
// Assumes one bit lasts 128 sys_clk cycles (tick every 8 cycles).
module ucs_periph (
    input wire logic sys_clk,
    output logic serial_in,
    output logic cts_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // Line drivers
    // ----------------------------------------------------------------
    initial begin
        serial_in = 1'h1;
        cts_n = 1'h0;
    end
    // Sets the clear-to-send level just after a clock edge.
    task automatic set_cts(input logic v);
        @(posedge sys_clk);
        #1 cts_n = v;
    endtask
    // Sends start, n bits LSB first, then the given stop level.
    task automatic send(input logic [8:0] bits, input int n, input logic stop);
        for (int i = 0; i <= n + 1; i++) begin
            @(posedge sys_clk);
            #1 serial_in = (i == 0) ? 1'h0 : (i <= n) ? bits[i-1] : stop;
            repeat (127) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        #1 serial_in = 1'h1;
        repeat (127) @(posedge sys_clk);
    endtask
endmodule

/* ucs_pkg.sv */
// Constants, types and helpers shared by the serial control block.
// Assumes a single system clock; the serial clocks arrive as sampled inputs.
package ucs_pkg;
    // ----------------------------------------------------------------
    // Control and status bit positions
    // ----------------------------------------------------------------
    localparam int CTL_PARITY_OFF = 0;
    localparam int CTL_EVEN_PARITY = 1;
    localparam int CTL_STOP_COUNT = 2;
    localparam int CTL_WORD_LO = 3;
    localparam int CTL_WORD_HI = 4;
    localparam int CTL_INT_GATE = 5;
    localparam int CTL_BREAK = 6;
    localparam int CTL_TX_REQUEST = 7;
    localparam int ST_RX_READY = 0;
    localparam int ST_OVERRUN = 1;
    localparam int ST_PARITY_ERR = 2;
    localparam int ST_FRAME_ERR = 3;
    localparam int ST_EXT_LEVEL = 4;
    localparam int ST_PERIPH_EDGE = 5;
    localparam int ST_SHIFT_EMPTY = 6;
    localparam int ST_HOLD_EMPTY = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // ----------------------------------------------------------------
    // Timing in serial clock ticks
    // ----------------------------------------------------------------
    localparam int TICKS_PER_BIT = 16;
    localparam logic [3:0] BIT_LAST = 4'(TICKS_PER_BIT - 1);
    localparam logic [3:0] MID_LAST = 4'(TICKS_PER_BIT / 2 - 1);
    localparam logic [5:0] STOP_ONE = 6'(TICKS_PER_BIT);
    localparam logic [5:0] STOP_HALF = 6'(TICKS_PER_BIT * 3 / 2);
    localparam logic [5:0] STOP_TWO = 6'(TICKS_PER_BIT * 2);
    typedef enum logic [2:0] {
        SER_IDLE = 3'h0,
        SER_START = 3'h1,
        SER_DATA = 3'h2,
        SER_PARITY = 3'h3,
        SER_STOP = 3'h4
    } ucs_ser_e;
    // Parity bit for the active data bits; even gives an even total.
    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl,
                                     input logic even);
        logic [7:0] mask;
        mask = 8'hFF >> (2'h3 - wl);
        return (^(d & mask)) ^ ~even;
    endfunction
    // Index of the last data bit for a word length code.
    function automatic logic [2:0] last_idx(input logic [1:0] wl);
        return {1'b1, wl};
    endfunction
endpackage

/* ucs_rx.sv */
// Receive shifter: start detect, mid-bit sampling, parity and stop check.
// Assumes tick is a one-cycle pulse at sixteen times the bit rate.
module ucs_rx (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic serial_in,
    input wire logic [1:0] wl,
    input wire logic parity_off,
    input wire logic even,
    output logic char_valid,
    output logic [7:0] char_data,
    output logic char_parity_err,
    output logic char_frame_err
);
    typedef struct packed {
        ucs_pkg::ucs_ser_e st;
        logic [3:0] cnt;
        logic [2:0] idx;
        logic [2:0] last;
        logic prev;
        logic [7:0] data;
        logic par_miss;
        logic valid;
        logic [7:0] out;
        logic parity_err;
        logic frame_err;
    } ucs_rx_s;
    ucs_rx_s q, d;
    logic bit_end;
    always_comb begin
        d = q;
        d.valid = 1'b0;
        bit_end = tick && (q.cnt == ucs_pkg::BIT_LAST);
        if (tick) begin
            d.cnt = q.cnt + 4'h1;
        end
        case (q.st)
            ucs_pkg::SER_IDLE: if (tick) begin
                d.prev = serial_in;
                if (q.prev && !serial_in) begin
                    d.st = ucs_pkg::SER_START;
                    d.cnt = 4'h0;
                    d.data = 8'h00;
                    d.par_miss = 1'b0;
                    d.last = ucs_pkg::last_idx(wl);
                end
            end
            ucs_pkg::SER_START: if (tick && q.cnt == ucs_pkg::MID_LAST) begin
                d.cnt = 4'h0;
                d.idx = 3'h0;
                d.st = serial_in ? ucs_pkg::SER_IDLE : ucs_pkg::SER_DATA;
            end
            ucs_pkg::SER_DATA: if (bit_end) begin
                d.data[q.idx] = serial_in;
                d.idx = q.idx + 3'h1;
                if (q.idx == q.last) begin
                    d.st = parity_off ? ucs_pkg::SER_STOP : ucs_pkg::SER_PARITY;
                end
            end
            ucs_pkg::SER_PARITY: if (bit_end) begin
                d.par_miss = serial_in ^ ucs_pkg::par_bit(q.data, wl, even);
                d.st = ucs_pkg::SER_STOP;
            end
            ucs_pkg::SER_STOP: if (bit_end) begin
                d.valid = 1'b1;
                d.out = q.data;
                d.parity_err = q.par_miss & ~parity_off;
                d.frame_err = ~serial_in;
                d.prev = serial_in;
                d.st = ucs_pkg::SER_IDLE;
            end
            default: d.st = ucs_pkg::SER_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: ucs_pkg::SER_IDLE, prev: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end
    assign char_valid = q.valid;
    assign char_data = q.out;
    assign char_parity_err = q.parity_err;
    assign char_frame_err = q.frame_err;
endmodule

/* ucs_tx.sv */
// Transmit shifter: start, data, optional parity and stop bits.
// Assumes tick is a one-cycle pulse at sixteen times the bit rate.
module ucs_tx (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic cts_n,
    input wire logic load_valid,
    input wire logic [7:0] load_data,
    input wire logic [1:0] wl,
    input wire logic stop_sel,
    input wire logic parity_off,
    input wire logic even,
    output logic load_take,
    output logic done,
    output logic line
);
    typedef struct packed {
        ucs_pkg::ucs_ser_e st;
        logic [5:0] cnt;
        logic [5:0] stop_len;
        logic [2:0] idx;
        logic [2:0] last;
        logic [7:0] sh;
        logic par;
        logic par_en;
        logic line;
        logic done;
    } ucs_tx_s;
    ucs_tx_s q, d;
    logic adv;
    logic bit_end;
    always_comb begin
        d = q;
        d.done = 1'b0;
        load_take = 1'b0;
        adv = tick & ~cts_n;
        bit_end = (q.cnt[3:0] == ucs_pkg::BIT_LAST);
        case (q.st)
            ucs_pkg::SER_IDLE: begin
                d.line = 1'b1;
                if (load_valid && !cts_n) begin
                    load_take = 1'b1;
                    d.st = ucs_pkg::SER_START;
                    d.line = 1'b0;
                    d.cnt = 6'h00;
                    d.idx = 3'h0;
                    d.sh = load_data;
                    d.last = ucs_pkg::last_idx(wl);
                    d.par = ucs_pkg::par_bit(load_data, wl, even);
                    d.par_en = ~parity_off;
                    d.stop_len = !stop_sel ? ucs_pkg::STOP_ONE :
                        (wl == 2'h0 ? ucs_pkg::STOP_HALF : ucs_pkg::STOP_TWO);
                end
            end
            ucs_pkg::SER_START: if (adv) begin
                d.cnt = q.cnt + 6'h01;
                if (bit_end) begin
                    d.st = ucs_pkg::SER_DATA;
                    d.cnt = 6'h00;
                    d.line = q.sh[0];
                end
            end
            ucs_pkg::SER_DATA: if (adv) begin
                d.cnt = q.cnt + 6'h01;
                if (bit_end) begin
                    d.cnt = 6'h00;
                    if (q.idx == q.last) begin
                        d.st = q.par_en ? ucs_pkg::SER_PARITY : ucs_pkg::SER_STOP;
                        d.line = q.par_en ? q.par : 1'b1;
                    end else begin
                        d.idx = q.idx + 3'h1;
                        d.sh = q.sh >> 1;
                        d.line = q.sh[1];
                    end
                end
            end
            ucs_pkg::SER_PARITY: if (adv) begin
                d.cnt = q.cnt + 6'h01;
                if (bit_end) begin
                    d.st = ucs_pkg::SER_STOP;
                    d.cnt = 6'h00;
                    d.line = 1'b1;
                end
            end
            ucs_pkg::SER_STOP: if (adv) begin
                d.cnt = q.cnt + 6'h01;
                if (q.cnt == q.stop_len - 6'h01) begin
                    d.st = ucs_pkg::SER_IDLE;
                    d.done = 1'b1;
                end
            end
            default: d.st = ucs_pkg::SER_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: ucs_pkg::SER_IDLE, line: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end
    assign done = q.done;
    assign line = q.line;
endmodule

/* ucs_uart.sv */
// Control, status and interrupt logic of the serial transceiver.
// Assumes bus, handshake and serial clock pins are synchronous to sys_clk.
// The serial clocks must run at no more than half of sys_clk.
// rst_n is the active-low clear pin of the device.

module ucs_uart (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cs1,
    input wire logic cs2_n,
    input wire logic cs3,
    input wire logic reg_select,
    input wire logic rd_wr,
    input wire logic bus_timing_strobe,
    input wire logic [7:0] tx_bus,
    output logic [7:0] rx_bus,
    output logic int_n,
    output logic rx_char_ready_n,
    output logic frame_err_out,
    output logic error_out,
    output logic tx_hold_empty_n,
    output logic rts_n,
    output logic serial_out,
    input wire logic serial_in,
    input wire logic rx_clk,
    input wire logic tx_clk,
    input wire logic cts_n,
    input wire logic ext_level_n,
    input wire logic periph_edge_n
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rx_hold;
        logic [7:0] tx_hold;
        logic tx_hold_full;
        logic rx_char_ready;
        logic overrun;
        logic rx_parity_err;
        logic rx_frame_err;
        logic ext_level_flag;
        logic periph_edge_irq;
        logic tx_shift_empty;
        logic tx_hold_empty;
        logic hold_irq;
        logic done_irq;
        logic cts_irq;
        logic brk_low;
        logic stat_pend;
        logic strobe_prev;
        logic cts_prev;
        logic periph_prev;
        logic rx_clk_prev;
        logic tx_clk_prev;
        logic int_n;
        logic rts_n;
        logic serial_out;
        logic [7:0] rx_bus;
    } ucs_regs_s;
    ucs_regs_s q, d;
    logic sel;
    logic lead;
    logic trail;
    logic wr_ctrl;
    logic wr_char;
    logic rd_stat;
    logic rd_data;
    logic cts_rise;
    logic periph_fall;
    logic rx_tick;
    logic tx_tick;
    logic any_src;
    logic [7:0] status;
    logic tx_take;
    logic tx_done;
    logic tx_line;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_perr;
    logic rx_ferr;
    // ----------------------------------------------------------------
    // Serial engines
    // ----------------------------------------------------------------
    ucs_tx u_tx (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(tx_tick),
        .cts_n(cts_n),
        .load_valid(q.tx_hold_full),
        .load_data(q.tx_hold),
        .wl(q.ctrl[ucs_pkg::CTL_WORD_HI:ucs_pkg::CTL_WORD_LO]),
        .stop_sel(q.ctrl[ucs_pkg::CTL_STOP_COUNT]),
        .parity_off(q.ctrl[ucs_pkg::CTL_PARITY_OFF]),
        .even(q.ctrl[ucs_pkg::CTL_EVEN_PARITY]),
        .load_take(tx_take),
        .done(tx_done),
        .line(tx_line)
    );
    ucs_rx u_rx (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(rx_tick),
        .serial_in(serial_in),
        .wl(q.ctrl[ucs_pkg::CTL_WORD_HI:ucs_pkg::CTL_WORD_LO]),
        .parity_off(q.ctrl[ucs_pkg::CTL_PARITY_OFF]),
        .even(q.ctrl[ucs_pkg::CTL_EVEN_PARITY]),
        .char_valid(rx_valid),
        .char_data(rx_data),
        .char_parity_err(rx_perr),
        .char_frame_err(rx_ferr)
    );
    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        sel = cs1 & ~cs2_n & cs3;
        lead = sel & bus_timing_strobe & ~q.strobe_prev;
        trail = ~bus_timing_strobe & q.strobe_prev;
        wr_ctrl = lead & ~rd_wr & reg_select;
        wr_char = lead & ~rd_wr & ~reg_select;
        rd_stat = lead & rd_wr & reg_select;
        rd_data = lead & rd_wr & ~reg_select;
        cts_rise = cts_n & ~q.cts_prev;
        periph_fall = q.periph_prev & ~periph_edge_n;
        rx_tick = rx_clk & ~q.rx_clk_prev;
        tx_tick = tx_clk & ~q.tx_clk_prev;
        // ------------------------------------------------------------
        // Status word
        // ------------------------------------------------------------
        status = 8'h00;
        status[ucs_pkg::ST_RX_READY] = q.rx_char_ready;
        status[ucs_pkg::ST_OVERRUN] = q.overrun;
        status[ucs_pkg::ST_PARITY_ERR] = q.rx_parity_err;
        status[ucs_pkg::ST_FRAME_ERR] = q.rx_frame_err;
        status[ucs_pkg::ST_EXT_LEVEL] = q.ext_level_flag;
        status[ucs_pkg::ST_PERIPH_EDGE] = q.periph_edge_irq;
        status[ucs_pkg::ST_SHIFT_EMPTY] = q.tx_shift_empty;
        status[ucs_pkg::ST_HOLD_EMPTY] = q.tx_hold_empty;
        d.strobe_prev = bus_timing_strobe;
        d.cts_prev = cts_n;
        d.periph_prev = periph_edge_n;
        d.rx_clk_prev = rx_clk;
        d.tx_clk_prev = tx_clk;
        // ------------------------------------------------------------
        // Register updates
        // ------------------------------------------------------------
        // Control register.
        if (wr_ctrl) begin
            if (tx_bus[ucs_pkg::CTL_TX_REQUEST]) begin
                d.ctrl[ucs_pkg::CTL_TX_REQUEST] = 1'b1;
            end else begin
                d.ctrl = tx_bus;
                d.brk_low = tx_bus[ucs_pkg::CTL_BREAK];
            end
        end
        if (!d.ctrl[ucs_pkg::CTL_BREAK] || cts_rise || tx_done) begin
            d.brk_low = 1'b0;
        end
        // Clears first so that a same-cycle event wins.
        if (rd_stat || wr_char) begin
            d.hold_irq = 1'b0;
            d.done_irq = 1'b0;
        end
        if (rd_stat) begin
            d.cts_irq = 1'b0;
            d.stat_pend = 1'b1;
        end
        if (rd_data) begin
            d.rx_char_ready = 1'b0;
        end
        if (trail && q.stat_pend) begin
            d.periph_edge_irq = 1'b0;
            d.stat_pend = 1'b0;
        end
        // Transmit side events.
        if (tx_take) begin
            d.tx_hold_full = 1'b0;
            d.tx_hold_empty = 1'b1;
            d.tx_shift_empty = 1'b0;
            if (q.ctrl[ucs_pkg::CTL_TX_REQUEST]) begin
                d.hold_irq = 1'b1;
            end
        end
        if (tx_done) begin
            // A new start bit in the same cycle keeps the flag low.
            d.tx_shift_empty = ~tx_take;
            if (!q.tx_hold_full) begin
                d.done_irq = 1'b1;
            end
        end
        if (cts_rise && q.tx_hold_empty && q.tx_shift_empty) begin
            d.cts_irq = 1'b1;
        end
        if (wr_char) begin
            d.tx_hold = tx_bus;
            d.tx_hold_full = 1'b1;
            d.tx_hold_empty = 1'b0;
        end
        // Receive side events.
        if (rx_valid) begin
            d.overrun = d.rx_char_ready;
            d.rx_hold = rx_data;
            d.rx_char_ready = 1'b1;
            d.rx_parity_err = rx_perr;
            d.rx_frame_err = rx_ferr;
        end
        if (d.ctrl[ucs_pkg::CTL_PARITY_OFF]) begin
            d.rx_parity_err = 1'b0;
        end
        // Peripheral status inputs.
        d.ext_level_flag = ~ext_level_n;
        if (periph_fall) begin
            d.periph_edge_irq = 1'b1;
        end
        // ------------------------------------------------------------
        // Outputs
        // ------------------------------------------------------------
        // Interrupt and pin outputs.
        any_src = d.rx_char_ready | d.hold_irq | d.done_irq | d.periph_edge_irq | d.cts_irq;
        d.int_n = ~(d.ctrl[ucs_pkg::CTL_INT_GATE] & any_src);
        if (d.tx_hold_full || d.ctrl[ucs_pkg::CTL_TX_REQUEST]) begin
            d.rts_n = 1'b0;
        end else if (d.tx_hold_empty && d.tx_shift_empty) begin
            d.rts_n = 1'b1;
        end
        d.serial_out = tx_line & ~d.brk_low;
        if (sel && rd_wr && bus_timing_strobe) begin
            d.rx_bus = reg_select ? status : q.rx_hold;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{ctrl: ucs_pkg::CTRL_RST, tx_shift_empty: 1'b1, tx_hold_empty: 1'b1,
                   strobe_prev: 1'b0, cts_prev: 1'b1, periph_prev: 1'b1,
                   int_n: 1'b1, rts_n: 1'b1, serial_out: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end
    // ----------------------------------------------------------------
    // Pins
    // ----------------------------------------------------------------
    assign rx_bus = q.rx_bus;
    assign int_n = q.int_n;
    assign rx_char_ready_n = ~q.rx_char_ready;
    assign frame_err_out = q.rx_frame_err;
    assign error_out = q.rx_parity_err | q.overrun;
    assign tx_hold_empty_n = ~q.tx_hold_empty;
    assign rts_n = q.rts_n;
    assign serial_out = q.serial_out;
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_parity_off_flag: assert property (q.ctrl[ucs_pkg::CTL_PARITY_OFF] |-> !q.rx_parity_err)
        else $error("Parity error flag set while parity is off.");
    a_gate_blocks_int: assert property (!q.ctrl[ucs_pkg::CTL_INT_GATE] |-> int_n)
        else $error("Interrupt asserted while gate is low.");
    a_break_holds_low: assert property (q.brk_low |-> !serial_out)
        else $error("Serial output high during break.");
    a_request_rts: assert property (q.ctrl[ucs_pkg::CTL_TX_REQUEST] |-> !rts_n)
        else $error("Request-to-send high with transmit request set.");
    a_request_write_keeps: assert property (wr_ctrl && tx_bus[ucs_pkg::CTL_TX_REQUEST]
        |=> q.ctrl[ucs_pkg::CTL_TX_REQUEST] && q.ctrl[6:0] == $past(q.ctrl[6:0]))
        else $error("Transmit request write changed other control bits.");
    a_ext_level_set: assert property (!ext_level_n |=> q.ext_level_flag)
        else $error("External status flag missed a low level.");
    a_periph_edge_int: assert property (periph_fall && q.ctrl[ucs_pkg::CTL_INT_GATE]
        && !wr_ctrl |=> q.periph_edge_irq && !int_n)
        else $error("Peripheral edge did not set flag and interrupt.");
    a_ready_pin: assert property (rx_valid |=> q.rx_char_ready && !rx_char_ready_n)
        else $error("Character ready not shown after receive transfer.");
    a_overrun_set: assert property (rx_valid && q.rx_char_ready && !rd_data |=> q.overrun)
        else $error("Overrun not flagged.");
    a_error_pin: assert property (error_out == (q.rx_parity_err || q.overrun))
        else $error("Error pin disagrees with flags.");
    a_shift_empty_seq: assert property (tx_take |=> !q.tx_shift_empty until_with tx_done)
        else $error("Shift empty set before character finished.");
    a_hold_empty_pin: assert property (tx_take && !wr_char |=> q.tx_hold_empty && !tx_hold_empty_n)
        else $error("Hold empty not shown after transfer.");
    a_cts_stalls: assert property (cts_n |-> !tx_take)
        else $error("Transmitter loaded while clear-to-send high.");
    a_rx_parity_upd: assert property (rx_valid && !q.ctrl[0] && !wr_ctrl |=> q.rx_parity_err == $past(rx_perr))
        else $error("Parity error flag not updated on transfer.");
    a_frame_pin_upd: assert property (rx_valid |=> frame_err_out == $past(rx_ferr))
        else $error("Framing error pin not updated on transfer.");
    a_shift_empty_set: assert property (tx_done && !tx_take |=> q.tx_shift_empty)
        else $error("Shift empty not set after character end.");
    a_cts_irq_set: assert property (cts_rise && q.tx_hold_empty && q.tx_shift_empty && q.ctrl[5] && !wr_ctrl |=> !int_n)
        else $error("Clear-to-send rise did not interrupt.");
    a_stat_read_clr: assert property (rd_stat && !cts_rise |=> !q.cts_irq)
        else $error("Status read did not clear clear-to-send source.");
    a_data_read_clr: assert property (rd_data && !rx_valid |=> !q.rx_char_ready)
        else $error("Data read did not clear character ready.");
    a_hold_irq_clr: assert property ((rd_stat || wr_char) && !tx_take && !tx_done |=> !q.hold_irq && !q.done_irq)
        else $error("Transmit sources not cleared by access.");
    a_break_ends: assert property (q.brk_low && cts_rise |=> !q.brk_low)
        else $error("Break not ended by clear-to-send rise.");
    a_rts_release: assert property (!q.ctrl[7] && !q.tx_hold_full && q.tx_hold_empty && q.tx_shift_empty && !wr_ctrl && !wr_char |=> rts_n)
        else $error("Request-to-send low with transmitter idle.");
    a_ctrl_write: assert property (wr_ctrl && !tx_bus[7] |=> q.ctrl == $past(tx_bus))
        else $error("Control write not stored.");
    a_status_read: assert property (rd_stat |=> rx_bus == $past(status))
        else $error("Status read returned wrong word.");
    a_data_read: assert property (rd_data |=> rx_bus == $past(q.rx_hold))
        else $error("Data read returned wrong word.");
    a_int_gate_src: assert property (q.ctrl[5] && q.rx_char_ready |-> !int_n)
        else $error("Enabled source did not interrupt.");
    a_overrun_clear: assert property (rx_valid && !q.rx_char_ready |=> !q.overrun)
        else $error("Overrun set without lost character.");
    a_ext_level_clr: assert property (ext_level_n |=> !q.ext_level_flag)
        else $error("External status flag set with high level.");
    c_char_received: cover property (rx_valid);
    c_char_sent: cover property (tx_done && q.ctrl[ucs_pkg::CTL_TX_REQUEST]);
    c_break_sent: cover property (q.brk_low ##1 !q.brk_low);
    c_cts_int: cover property (cts_rise && q.tx_hold_empty && q.tx_shift_empty);
endmodule
